// ===== include/dpm_pkg.sv
// constants and types shared by the loop mode and status logic
package dpm_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_TIME_NS   = 3000000;
    localparam int RST_CYCLES    = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // mode codes of the two mode pins
    // ---------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_HOLDOVER = 2'h1;
    localparam logic [1:0] MODE_FREERUN  = 2'h2;
    localparam logic [1:0] MODE_AUTO     = 2'h3;

    // ---------------------------------------------------------------
    // out-of-range limits, in frequency offset units
    // ---------------------------------------------------------------
    localparam logic [15:0] OOR_LIMIT_LO = 16'h0020;
    localparam logic [15:0] OOR_LIMIT_HI = 16'h0040;

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    localparam logic [1:0] ADDR_INT_STAT = 2'h0;
    localparam logic [1:0] ADDR_INT_MASK = 2'h1;
    localparam logic [1:0] ADDR_STATUS   = 2'h2;
    localparam logic [4:0] INT_MASK_RST  = 5'h00;
    localparam int EV_HOLD  = 0;
    localparam int EV_FAILA = 1;
    localparam int EV_LOCKL = 4;

    // per-reference monitor result from the loop
    typedef struct packed {
        logic [15:0] freq_off;   // magnitude of frequency offset
        logic        phase_jump;
        logic        freq_step;
    } dpm_refmon_t;

    // status pins; their common enable status_oe is a separate output
    typedef struct packed {
        logic       holdover;
        logic       lock;
        logic [2:0] fail;        // c, b, a
    } dpm_status_t;

    typedef enum logic [1:0] {
        SEL_A, SEL_B, SEL_C
    } dpm_sel_t;

endpackage

// ===== hdl/dpm_ctrl.sv
// mode control, reference failure and status indication of the loop
//
// Notes on behaviour
// (R1) holdover flag high exactly while the loop is in holdover.
// (R2) a reference fails when its offset exceeds the selected range limit.
// (R3) phase jumps or frequency steps also fail a reference.
// (R4) three separate high-active failure flags, each for its own reference.
// (R5) hitless select low: keep stored corrector delay when returning to normal.
// (R6) hitless select high: measure a fresh corrector delay on that return.
// (R7) hitless choice applies only when the same reference stays selected.
// (R8) the two mode bits decode together as one two-bit mode code.
// (R9) code 11 enters automatic reference selection.
// (R10) lock flag rises when the loop is locked to the selected reference.
// (R11) after reset release, internal reset lasts 3 ms with the status pins floating (status_oe low).
// (R12) control inputs are synchronised; status flags come from registers.
`timescale 1ns/1ps

module dpm_ctrl
    import dpm_pkg::*;
#(
    parameter int unsigned RST_CYCLES_P = RST_CYCLES
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // controller pins
    input  wire logic        op_mode_bit0,
    input  wire logic        op_mode_bit1,
    input  wire logic [1:0]  manual_ref_sel,
    input  wire logic        range_limit_select,
    input  wire logic        hitless_switch_sel,
    // loop monitors
    input  wire dpm_refmon_t ref_a_in,
    input  wire dpm_refmon_t ref_b_in,
    input  wire dpm_refmon_t ref_c_in,
    input  wire logic        loop_freq_locked,
    // status pins
    output dpm_status_t      status_out,
    output logic             status_oe,
    // loop control
    output dpm_sel_t         ref_select,
    output logic             corr_measure,
    output logic             corr_keep,
    // register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             irq
);

    typedef enum logic [1:0] {
        ST_RESET, ST_FREERUN, ST_NORMAL, ST_HOLDOVER
    } dpm_state_t;

    dpm_state_t  st_q, st_d;
    dpm_sel_t    sel_q, sel_d;
    logic [15:0] rst_cnt_q;
    logic [1:0]  mode_m_q, mode_s_q;
    logic [1:0]  msel_m_q, msel_s_q;
    logic        lim_m_q, lim_s_q, hit_m_q, hit_s_q;
    logic [2:0]  fail_raw;
    logic [2:0]  oor;
    logic [15:0] limit;
    logic        sel_fail, lock_raw;
    logic        rejoin;
    logic [4:0]  int_stat_q, int_mask_q, ev;

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    // pins are driven by a foreign controller, so retime before decode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_m_q <= 2'h0;
            mode_s_q <= 2'h0;
            msel_m_q <= 2'h0;
            msel_s_q <= 2'h0;
            lim_m_q  <= 1'b0;
            lim_s_q  <= 1'b0;
            hit_m_q  <= 1'b0;
            hit_s_q  <= 1'b0;
        end else begin
            mode_m_q <= {op_mode_bit1, op_mode_bit0}; // [R8] [R12]
            mode_s_q <= mode_m_q;
            msel_m_q <= manual_ref_sel;
            msel_s_q <= msel_m_q;
            lim_m_q  <= range_limit_select;           // [R12]
            lim_s_q  <= lim_m_q;
            hit_m_q  <= hitless_switch_sel;           // [R12]
            hit_s_q  <= hit_m_q;
        end
    end

    // ---------------------------------------------------------------
    // reference qualification
    // ---------------------------------------------------------------
    // each flag looks only at its own monitor
    assign limit = lim_s_q ? OOR_LIMIT_HI : OOR_LIMIT_LO;
    assign oor[0] = ref_a_in.freq_off > limit;               // [R2]
    assign oor[1] = ref_b_in.freq_off > limit;               // [R2]
    assign oor[2] = ref_c_in.freq_off > limit;               // [R2]
    assign fail_raw[0] = oor[0] | ref_a_in.phase_jump | ref_a_in.freq_step; // [R3] [R4]
    assign fail_raw[1] = oor[1] | ref_b_in.phase_jump | ref_b_in.freq_step; // [R3] [R4]
    assign fail_raw[2] = oor[2] | ref_c_in.phase_jump | ref_c_in.freq_step; // [R3] [R4]

    // ---------------------------------------------------------------
    // reference selection
    // ---------------------------------------------------------------
    // automatic mode is revertive: the lowest healthy reference wins
    always_comb begin
        sel_d = sel_q;
        if (mode_s_q == MODE_AUTO) begin                     // [R9]
            if (!fail_raw[0])
                sel_d = SEL_A;
            else if (!fail_raw[1])
                sel_d = SEL_B;
            else if (!fail_raw[2])
                sel_d = SEL_C;
        end else begin
            unique case (msel_s_q)
                2'h1:    sel_d = SEL_B;
                2'h2:    sel_d = SEL_C;
                default: sel_d = SEL_A;                      // code 3 aliases a
            endcase
        end
    end

    assign sel_fail = fail_raw[sel_d];

    // ---------------------------------------------------------------
    // mode state machine
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RESET:
                if (rst_cnt_q == 16'(RST_CYCLES_P - 1))      // [R11]
                    st_d = ST_FREERUN;
            ST_FREERUN, ST_HOLDOVER, ST_NORMAL: begin
                unique case (mode_s_q)                       // [R8]
                    MODE_FREERUN:  st_d = ST_FREERUN;
                    MODE_HOLDOVER: st_d = ST_HOLDOVER;
                    default: begin
                        // failure of the selected reference sends a running loop to holdover
                        if (!sel_fail)
                            st_d = ST_NORMAL;
                        else if (st_q == ST_NORMAL)
                            st_d = ST_HOLDOVER;
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_q  <= ST_RESET;
            sel_q <= SEL_A;
        end else begin
            st_q  <= st_d;
            sel_q <= (st_q == ST_RESET) ? SEL_A : sel_d;
        end
    end

    // internal reset timer, only runs while the machine is in reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            rst_cnt_q <= 16'h0000;
        else if (st_q == ST_RESET)
            rst_cnt_q <= rst_cnt_q + 16'h0001;               // [R11]
    end

    // ---------------------------------------------------------------
    // phase error corrector control
    // ---------------------------------------------------------------
    // re-entry to normal from holdover or freerun
    assign rejoin = (st_d == ST_NORMAL) &&
                    (st_q == ST_HOLDOVER || st_q == ST_FREERUN);

    // a reference change as the loop enters or stays in normal needs a fresh delay, whatever the pin says
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            corr_measure <= 1'b0;
            corr_keep    <= 1'b0;
        end else begin
            corr_measure <= (rejoin && sel_d == sel_q && hit_s_q) ||   // [R6] [R7]
                            (st_d == ST_NORMAL && sel_d != sel_q);
            corr_keep    <= rejoin && sel_d == sel_q && !hit_s_q;      // [R5] [R7]
        end
    end

    // ---------------------------------------------------------------
    // status pins
    // ---------------------------------------------------------------
    assign lock_raw = loop_freq_locked && st_q == ST_NORMAL;

    // registered so the pins never glitch on monitor updates
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_out <= '0;
            status_oe  <= 1'b0;
            ref_select <= SEL_A;
        end else begin
            status_out.holdover <= st_q == ST_HOLDOVER;    // [R1] [R12]
            status_out.lock     <= lock_raw;               // [R10]
            status_out.fail     <= fail_raw;               // [R4] [R12]
            status_oe           <= st_q != ST_RESET;       // [R11]
            ref_select          <= sel_q;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, mask and register port
    // ---------------------------------------------------------------
    assign ev[EV_HOLD]             = (st_q == ST_HOLDOVER) && !status_out.holdover;
    assign ev[EV_FAILA +: 3]       = fail_raw & ~status_out.fail;
    assign ev[EV_LOCKL]            = status_out.lock && !lock_raw;

    // a new event wins over a write-one-to-clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            int_stat_q <= 5'h00;
        else if (reg_wr && reg_addr == ADDR_INT_STAT)
            int_stat_q <= (int_stat_q & ~reg_wdata[4:0]) | ev;
        else
            int_stat_q <= int_stat_q | ev;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            int_mask_q <= INT_MASK_RST;
        else if (reg_wr && reg_addr == ADDR_INT_MASK)
            int_mask_q <= reg_wdata[4:0];
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_INT_STAT: reg_rdata <= {3'h0, int_stat_q};
                ADDR_INT_MASK: reg_rdata <= {3'h0, int_mask_q};
                ADDR_STATUS:   reg_rdata <= {st_q, sel_q, status_out.fail, status_out.lock};
                default:       reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic in_hold, a_fail_cause, b_fail_cause;
    assign in_hold      = st_q == ST_HOLDOVER;
    assign a_fail_cause = oor[0] || ref_a_in.phase_jump;
    // worked out again from b's own monitor, so a crossed index shows up
    assign b_fail_cause = (ref_b_in.freq_off > limit) || ref_b_in.phase_jump || ref_b_in.freq_step;

    sequence s_rejoin_same;
        rejoin && sel_d == sel_q;
    endsequence

    property p_hold_flag;
        ##1 status_out.holdover == $past(in_hold);
    endproperty
    a_hold_flag: assert property (p_hold_flag) else $error("holdover flag wrong"); // [R1]

    property p_oor_fail;
        a_fail_cause |=> status_out.fail[0];
    endproperty
    a_oor_fail: assert property (p_oor_fail) else $error("ref a fail missed"); // [R2]

    property p_step_fail;
        ref_c_in.freq_step |=> status_out.fail[2];
    endproperty
    a_step_fail: assert property (p_step_fail) else $error("ref c step missed"); // [R3]

    property p_own_flag;
        ##1 status_out.fail[1] == $past(b_fail_cause);
    endproperty
    a_own_flag: assert property (p_own_flag) else $error("ref b flag mixed"); // [R4]

    property p_keep;
        (s_rejoin_same and !hit_s_q) |=> corr_keep && !corr_measure;
    endproperty
    a_keep: assert property (p_keep) else $error("delay not kept"); // [R5]

    property p_measure;
        (s_rejoin_same and hit_s_q) |=> corr_measure && !corr_keep;
    endproperty
    a_measure: assert property (p_measure) else $error("delay not measured"); // [R6]

    property p_keep_only_rejoin;
        corr_keep |-> $past(st_q) != ST_NORMAL && st_q == ST_NORMAL;
    endproperty
    a_keep_only_rejoin: assert property (p_keep_only_rejoin) else $error("stray keep"); // [R7]

    property p_freerun_code;
        (mode_s_q == MODE_FREERUN && st_q != ST_RESET) |=> st_q == ST_FREERUN;
    endproperty
    a_freerun_code: assert property (p_freerun_code) else $error("mode decode wrong"); // [R8]

    property p_auto_pick;
        (mode_s_q == MODE_AUTO && !fail_raw[0] && st_q != ST_RESET) |=> sel_q == SEL_A;
    endproperty
    a_auto_pick: assert property (p_auto_pick) else $error("auto select wrong"); // [R9]

    property p_lock;
        ##1 status_out.lock == $past(lock_raw);
    endproperty
    a_lock: assert property (p_lock) else $error("lock flag wrong"); // [R10]

    property p_reset_float;
        st_q == ST_RESET |=> !status_oe;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pins driven in reset"); // [R11]

    // the pin sample taken at the release edge was lost to reset, so skip it
    property p_sync;
        !$past(rst) |-> ##2 mode_s_q == $past({op_mode_bit1, op_mode_bit0}, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("mode sync wrong"); // [R12]

endmodule

// ===== test/dpm_ctl_model.sv
// controller model that drives the mode, limit, hitless and manual select pins
`timescale 1ns/1ps

module dpm_ctl_model
    import dpm_pkg::*;
(
    // clock
    input  wire logic  mclk,
    // controller pins
    output logic       op_mode_bit0,
    output logic       op_mode_bit1,
    output logic [1:0] manual_ref_sel,
    output logic       range_limit_select,
    output logic       hitless_switch_sel
);
    // -------------------------------------------
    // pin drive
    // -------------------------------------------
    // power-up levels: freerun, reference a, low limit, keep delay
    initial begin
        {op_mode_bit1, op_mode_bit0} = MODE_FREERUN;
        manual_ref_sel = 2'h0;
        range_limit_select = 1'b0;
        hitless_switch_sel = 1'b0;
    end

    // both bits move at one edge, so no stray code is ever decoded
    task automatic set_mode(input logic [1:0] m);
        @(posedge mclk);
        {op_mode_bit1, op_mode_bit0} <= m;
    endtask

    // static selects, changed together right after an edge
    task automatic set_pins(input logic [1:0] sel, input logic lim, input logic hit);
        @(posedge mclk);
        manual_ref_sel <= sel;
        range_limit_select <= lim;
        hitless_switch_sel <= hit;
    endtask
endmodule

// ===== test/test_dpm_ctrl.sv
// self-checking bench for the loop mode and status logic
`timescale 1ns/1ps

module test_dpm_ctrl
    import dpm_pkg::*;
;
    // -------------------------------------------
    // signals
    // -------------------------------------------
    localparam int RST_N = 20; // shortened internal reset
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        op_mode_bit0, op_mode_bit1, range_limit_select, hitless_switch_sel;
    logic [1:0]  manual_ref_sel;
    dpm_refmon_t mon [3];
    logic        loop_freq_locked = 1'b0;
    dpm_status_t status_out;
    logic        status_oe, corr_measure, corr_keep, irq;
    dpm_sel_t    ref_select;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    int          err_total = 0;
    int          n_tests = 0;
    int          n_keep = 0;
    int          n_meas = 0;

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    dpm_ctl_model u_ctl (.mclk(mclk), .op_mode_bit0(op_mode_bit0),
        .op_mode_bit1(op_mode_bit1), .manual_ref_sel(manual_ref_sel),
        .range_limit_select(range_limit_select), .hitless_switch_sel(hitless_switch_sel));

    dpm_ctrl #(.RST_CYCLES_P(RST_N)) u_dut (.mclk(mclk), .rst(rst),
        .op_mode_bit0(op_mode_bit0), .op_mode_bit1(op_mode_bit1),
        .manual_ref_sel(manual_ref_sel), .range_limit_select(range_limit_select),
        .hitless_switch_sel(hitless_switch_sel), .ref_a_in(mon[0]), .ref_b_in(mon[1]),
        .ref_c_in(mon[2]), .loop_freq_locked(loop_freq_locked), .status_out(status_out),
        .status_oe(status_oe), .ref_select(ref_select), .corr_measure(corr_measure),
        .corr_keep(corr_keep), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    // corrector pulses are one cycle wide, so they are counted, not sampled
    always @(posedge mclk) begin
        if (corr_keep === 1'b1) n_keep <= n_keep + 1;
        if (corr_measure === 1'b1) n_meas <= n_meas + 1;
    end

    // -------------------------------------------
    // helpers
    // -------------------------------------------
    task automatic conclude();
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask

    // lands 1 ns past the edge so registered outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // -------------------------------------------
    // scenarios
    // -------------------------------------------
    task automatic t_reset();
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        settle(RST_N / 2);
        chk("oe_in_reset", 8'h00, {7'h0, status_oe});
        settle(RST_N);
        chk("oe_after_reset", 8'h01, {7'h0, status_oe});
        chk("hold_freerun", 8'h00, {7'h0, status_out.holdover});
    endtask

    // offset at the limit passes, one above fails; jumps and steps fail alone
    task automatic t_fail();
        logic [15:0] lim;
        logic [2:0]  exp;
        for (int l = 0; l < 2; l++) begin
            u_ctl.set_pins(2'h0, l[0], 1'b0);
            lim = l[0] ? OOR_LIMIT_HI : OOR_LIMIT_LO;
            for (int i = 0; i < 3; i++) begin
                for (int k = 0; k < 4; k++) begin
                    @(posedge mclk);
                    mon[i].freq_off <= (k == 1) ? lim + 16'h1 : lim;
                    mon[i].phase_jump <= (k == 2);
                    mon[i].freq_step <= (k == 3);
                    settle(4);
                    exp = (k == 0) ? 3'h0 : 3'(1 << i);
                    chk("fail_flags", {5'h0, exp}, {5'h0, status_out.fail});
                end
                @(posedge mclk);
                mon[i] <= '0;
            end
        end
        u_ctl.set_pins(2'h0, 1'b0, 1'b0);
        settle(4);
    endtask

    task automatic t_modes();
        @(posedge mclk);
        loop_freq_locked <= 1'b1;
        u_ctl.set_mode(MODE_NORMAL);
        settle(6);
        chk("lock_normal", 8'h01, {7'h0, status_out.lock});
        chk("hold_normal", 8'h00, {7'h0, status_out.holdover});
        u_ctl.set_mode(MODE_HOLDOVER);
        settle(6);
        chk("hold_holdover", 8'h01, {7'h0, status_out.holdover});
        chk("lock_holdover", 8'h00, {7'h0, status_out.lock});
        u_ctl.set_mode(MODE_FREERUN);
        settle(6);
        chk("hold_freerun2", 8'h00, {7'h0, status_out.holdover});
    endtask

    task automatic t_hitless();
        logic [1:0] src [2];
        src[0] = MODE_HOLDOVER;
        src[1] = MODE_FREERUN;
        for (int s = 0; s < 2; s++) begin
            for (int h = 0; h < 2; h++) begin
                u_ctl.set_mode(src[s]);
                u_ctl.set_pins(2'h0, 1'b0, h[0]);
                settle(6);
                n_keep = 0;
                n_meas = 0;
                u_ctl.set_mode(MODE_NORMAL);
                settle(8);
                chk("keep_pulses", 8'(1 - h), 8'(n_keep));
                chk("measure_pulses", 8'(h), 8'(n_meas));
            end
        end
        // a swap of reference in normal always measures afresh
        n_keep = 0;
        n_meas = 0;
        u_ctl.set_pins(2'h1, 1'b0, 1'b0);
        settle(8);
        chk("sel_manual_b", 8'(SEL_B), 8'(ref_select));
        chk("keep_on_swap", 8'h00, 8'(n_keep));
        chk("meas_on_swap", 8'h01, 8'(n_meas));
        u_ctl.set_pins(2'h2, 1'b0, 1'b0);
        settle(8);
        chk("sel_manual_c", 8'(SEL_C), 8'(ref_select));
        // code 3 is an alias of reference a
        u_ctl.set_pins(2'h3, 1'b0, 1'b0);
        settle(8);
        chk("sel_manual_alias", 8'(SEL_A), 8'(ref_select));
        u_ctl.set_pins(2'h0, 1'b0, 1'b0);
        settle(8);
    endtask

    task automatic t_auto();
        u_ctl.set_mode(MODE_AUTO);
        settle(6);
        chk("auto_a", 8'(SEL_A), 8'(ref_select));
        @(posedge mclk);
        mon[0].phase_jump <= 1'b1;
        settle(8);
        chk("auto_b", 8'(SEL_B), 8'(ref_select));
        @(posedge mclk);
        mon[1].freq_step <= 1'b1;
        settle(8);
        chk("auto_c", 8'(SEL_C), 8'(ref_select));
        @(posedge mclk);
        mon[0] <= '0;
        mon[1] <= '0;
        settle(8);
        chk("auto_back_a", 8'(SEL_A), 8'(ref_select));
    endtask

    // holdover entry event: masked, unmasked, cleared; unmapped address
    task automatic t_regs();
        logic [7:0] d;
        u_ctl.set_mode(MODE_NORMAL);
        settle(6);
        reg_write(ADDR_INT_MASK, 8'h00);
        reg_write(ADDR_INT_STAT, 8'h1f);
        u_ctl.set_mode(MODE_HOLDOVER);
        settle(6);
        chk("irq_masked", 8'h00, {7'h0, irq});
        reg_read(ADDR_INT_STAT, d);
        // holdover entry and lock lost both land in the same move
        chk("stat_hold", 8'h11, d);
        reg_read(ADDR_STATUS, d);
        chk("status_reg", 8'hc0, d);
        reg_write(ADDR_INT_MASK, 8'h01);
        settle(2);
        chk("irq_on", 8'h01, {7'h0, irq});
        reg_read(ADDR_INT_MASK, d);
        chk("mask_back", 8'h01, d);
        reg_write(ADDR_INT_STAT, 8'h01);
        settle(2);
        chk("irq_cleared", 8'h00, {7'h0, irq});
        reg_write(2'h3, 8'hff);
        reg_read(2'h3, d);
        chk("unmapped", 8'h00, d);
    endtask

    // -------------------------------------------
    // sequence and watchdog
    // -------------------------------------------
    initial begin
        foreach (mon[i]) mon[i] = '0;
        t_reset();
        t_fail();
        t_modes();
        t_hitless();
        t_auto();
        t_regs();
        conclude();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        conclude();
    end
endmodule
